// >>> verilog/timer_counter_pwm_unit.v
// Notes on behaviour
// - Modes compare, capture, quadrature, PWM, pseudo-random PWM, dead-time PWM; complementary pair.
// - Counter counts up, down, or up then down, as configured.
// - Prescaler divides the clock by a power of two from 1 to 128.
// - Period and compare/capture each have a staging buffer register.
// - Separate underflow, overflow and capture/compare output signals.
// - Terminal-count interrupt, normally on overflow or underflow by mode.
// - Capture/compare interrupt on capture into register or count equal compare.
// - Start, reload, stop, count, capture inputs each pick a routed trigger.
// - Each event input senses rising, falling, both edges or level.
// - While kill is asserted outputs are forced to a preset state.
// - Block holds eight 32-bit and twenty-four 16-bit units; this project holds one unit, CNT_WIDTH bits wide.
//
// The Avalon-MM interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "timer_counter_pwm_consts.vh"

module timer_counter_pwm_unit #(
  parameter CNT_WIDTH  = 32,
  parameter TRIG_COUNT = 15
) (
  input  wire                  mclk_i,
  input  wire                  sys_rst_i,
  input  wire [7:0]            avs_address_i,
  input  wire                  avs_read_i,
  input  wire                  avs_write_i,
  input  wire [31:0]           avs_writedata_i,
  input  wire [3:0]            avs_byteenable_i,
  output reg  [31:0]           avs_readdata_o,
  output wire                  avs_waitrequest_o,
  input  wire [TRIG_COUNT-1:0] trig_i,
  input  wire                  kill_i,
  output reg                   line_o,
  output reg                   line_n_o,
  output reg                   overflow_o,
  output reg                   underflow_o,
  output reg                   cc_match_o,
  output wire                  irq_o
);

  localparam CW = CNT_WIDTH;

  // ==========================================
  // Helpers
  function [31:0] be_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  be;
    integer i;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        be_merge[i*8 +: 8] = be[i] ? new_v[i*8 +: 8] : old_v[i*8 +: 8];
      end
    end
  endfunction

  function [31:0] ext;
    input [CW-1:0] v;
    integer i;
    begin
      ext = 32'h0;
      for (i = 0; i < CW; i = i + 1) begin
        ext[i] = v[i];
      end
    end
  endfunction

  // ==========================================
  // Registers
  reg  [`CTRL_W-1:0]        ctrl_reg;
  reg  [CW-1:0]             counter_reg;
  reg  [CW-1:0]             period_reg;
  reg  [CW-1:0]             period_buf_reg;
  reg  [CW-1:0]             cc_reg;
  reg  [CW-1:0]             cc_buf_reg;
  reg  [`EVT_NUM*4-1:0]     trig_sel_reg;
  reg  [`EVT_NUM*2-1:0]     trig_edge_reg;
  reg  [7:0]                deadtime_reg;
  reg  [1:0]                intr_reg;
  reg  [1:0]                intr_mask_reg;
  reg                       ack_reg;
  reg                       running_reg;
  reg                       down_reg;
  reg                       tc_reg;
  reg                       raw_d_reg;
  reg  [7:0]                dead_cnt_reg;
  reg                       kill_s1_reg;
  reg                       kill_s2_reg;
  reg  [31:0]               rdata;
  reg                       pwm_raw;
  reg  [CW-1:0]             rev_cnt;
  integer                   k;

  wire       enable    = ctrl_reg[`CTRL_EN];
  wire [2:0] mode      = ctrl_reg[`CTRL_MODE_LSB +: 3];
  wire [1:0] dir       = ctrl_reg[`CTRL_DIR_LSB +: 2];
  wire       quad_mode = (mode == `MODE_QUAD);
  wire       cap_mode  = (mode == `MODE_CAPTURE);

  // ==========================================
  // Avalon-MM slave: one wait cycle, then answer
  wire       req  = avs_read_i | avs_write_i;
  wire       wr   = avs_write_i & ack_reg;
  wire [5:0] widx = avs_address_i[7:2];
  wire [31:0] wmerge_ctrl = be_merge({19'h0, ctrl_reg}, avs_writedata_i, avs_byteenable_i);
  wire [31:0] wmerge_cnt  = be_merge(ext(counter_reg), avs_writedata_i, avs_byteenable_i);
  wire [31:0] wmerge_per  = be_merge(ext(period_reg), avs_writedata_i, avs_byteenable_i);
  wire [31:0] wmerge_pbuf = be_merge(ext(period_buf_reg), avs_writedata_i, avs_byteenable_i);
  wire [31:0] wmerge_cc   = be_merge(ext(cc_reg), avs_writedata_i, avs_byteenable_i);
  wire [31:0] wmerge_cbuf = be_merge(ext(cc_buf_reg), avs_writedata_i, avs_byteenable_i);
  wire [31:0] wmerge_tsel = be_merge({12'h0, trig_sel_reg}, avs_writedata_i, avs_byteenable_i);
  wire [31:0] wmerge_tedg = be_merge({22'h0, trig_edge_reg}, avs_writedata_i, avs_byteenable_i);
  wire [31:0] wmerge_dt   = be_merge({24'h0, deadtime_reg}, avs_writedata_i, avs_byteenable_i);
  wire [31:0] wmerge_msk  = be_merge({30'h0, intr_mask_reg}, avs_writedata_i, avs_byteenable_i);
  wire [3:0]  cmd_bits    = (wr && widx == `OFF_CMD >> 2 && avs_byteenable_i[0]) ?
                            avs_writedata_i[3:0] : 4'h0;
  wire [1:0]  intr_clr    = (wr && widx == `OFF_INTR >> 2 && avs_byteenable_i[0]) ?
                            avs_writedata_i[1:0] : 2'h0;

  assign avs_waitrequest_o = req & ~ack_reg;

  always @* begin
    if (widx == `OFF_CTRL >> 2) begin
      rdata = {19'h0, ctrl_reg};
    end else if (widx == `OFF_COUNTER >> 2) begin
      rdata = ext(counter_reg);
    end else if (widx == `OFF_PERIOD >> 2) begin
      rdata = ext(period_reg);
    end else if (widx == `OFF_PERIOD_BUF >> 2) begin
      rdata = ext(period_buf_reg);
    end else if (widx == `OFF_CC >> 2) begin
      rdata = ext(cc_reg);
    end else if (widx == `OFF_CC_BUF >> 2) begin
      rdata = ext(cc_buf_reg);
    end else if (widx == `OFF_TRIG_SEL >> 2) begin
      rdata = {12'h0, trig_sel_reg};
    end else if (widx == `OFF_TRIG_EDGE >> 2) begin
      rdata = {22'h0, trig_edge_reg};
    end else if (widx == `OFF_DEADTIME >> 2) begin
      rdata = {24'h0, deadtime_reg};
    end else if (widx == `OFF_INTR >> 2) begin
      rdata = {30'h0, intr_reg};
    end else if (widx == `OFF_INTR_MASK >> 2) begin
      rdata = {30'h0, intr_mask_reg};
    end else if (widx == `OFF_STATUS >> 2) begin
      rdata = {27'h0, kill_s2_reg, line_n_o, line_o, down_reg, running_reg};
    end else begin
      rdata = 32'h0;
    end
  end

  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ack_reg        <= 1'b0;
      avs_readdata_o <= 32'h0;
    end else begin
      ack_reg <= req & ~ack_reg;
      if (avs_read_i && !ack_reg) begin
        avs_readdata_o <= rdata;
      end
    end
  end

  // ==========================================
  // Trigger selection and edge sensing
  wire [TRIG_COUNT:0]   src = {1'b1, trig_i}; // Top index is constant high
  wire [`EVT_NUM-1:0]   evt;
  wire [`EVT_NUM-1:0]   lvl;
  wire [`EVT_NUM-1:0]   prv;

  genvar g;
  generate
    for (g = 0; g < `EVT_NUM; g = g + 1) begin : g_evt
      event_sense u_sense (
        .mclk_i    (mclk_i),
        .sys_rst_i (sys_rst_i),
        .raw_i     (src[trig_sel_reg[g*4 +: 4]]),
        .sense_i   (trig_edge_reg[g*2 +: 2]),
        .level_o   (lvl[g]),
        .prev_o    (prv[g]),
        .event_o   (evt[g])
      );
    end
  endgenerate

  wire sw_start   = cmd_bits[`CMD_START];
  wire sw_reload  = cmd_bits[`CMD_RELOAD];
  wire sw_stop    = cmd_bits[`CMD_STOP];
  wire sw_capture = cmd_bits[`CMD_CAPTURE];
  wire start_e    = enable & ~quad_mode & (evt[`EVT_START] | sw_start);
  wire reload_e   = enable & (evt[`EVT_RELOAD] | sw_reload);
  wire stop_e     = enable & ~quad_mode & (evt[`EVT_STOP] | sw_stop);
  wire capture_e  = enable & cap_mode & (evt[`EVT_CAPTURE] | sw_capture);

  // Quadrature: phase A on count slot, phase B on start slot, index on reload
  wire qa     = lvl[`EVT_COUNT];
  wire qb     = lvl[`EVT_START];
  wire q_step = (qa ^ prv[`EVT_COUNT]) | (qb ^ prv[`EVT_START]);
  wire q_up   = prv[`EVT_COUNT] ^ qb;

  // ==========================================
  // Prescaler and count enable
  wire pre_tick;

  prescaler u_pre (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .enable_i  (enable),
    .div_sel_i (ctrl_reg[`CTRL_PRE_LSB +: 3]),
    .tick_o    (pre_tick)
  );

  wire tick = running_reg & pre_tick & evt[`EVT_COUNT];

  // ==========================================
  // Counter core
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      counter_reg <= {CW{1'b0}};
      running_reg <= 1'b0;
      down_reg    <= 1'b0;
      overflow_o  <= 1'b0;
      underflow_o <= 1'b0;
      cc_match_o  <= 1'b0;
      tc_reg      <= 1'b0;
    end else begin
      overflow_o  <= 1'b0;
      underflow_o <= 1'b0;
      cc_match_o  <= 1'b0;
      tc_reg      <= 1'b0;
      if (!enable || stop_e) begin
        running_reg <= 1'b0;
      end else if (start_e || reload_e) begin
        running_reg <= 1'b1;
      end
      if (wr && widx == `OFF_COUNTER >> 2) begin
        counter_reg <= wmerge_cnt[CW-1:0];
      end else if (reload_e) begin
        counter_reg <= (dir == `DIR_DOWN && !quad_mode) ? period_reg : {CW{1'b0}};
        down_reg    <= (dir == `DIR_DOWN);
      end else if (capture_e) begin
        cc_match_o <= 1'b1;
      end else if (enable && quad_mode && q_step) begin
        if (q_up) begin
          if (counter_reg == period_reg) begin
            counter_reg <= {CW{1'b0}};
            overflow_o  <= 1'b1;
            tc_reg      <= 1'b1;
          end else begin
            counter_reg <= counter_reg + 1'b1;
          end
        end else begin
          if (counter_reg == {CW{1'b0}}) begin
            counter_reg <= period_reg;
            underflow_o <= 1'b1;
            tc_reg      <= 1'b1;
          end else begin
            counter_reg <= counter_reg - 1'b1;
          end
        end
      end else if (tick && !quad_mode) begin
        cc_match_o <= ~cap_mode & (counter_reg == cc_reg);
        case (dir)
          `DIR_UP: begin
            if (counter_reg == period_reg) begin
              counter_reg <= {CW{1'b0}};
              overflow_o  <= 1'b1;
              tc_reg      <= 1'b1;
            end else begin
              counter_reg <= counter_reg + 1'b1;
            end
          end
          `DIR_DOWN: begin
            if (counter_reg == {CW{1'b0}}) begin
              counter_reg <= period_reg;
              underflow_o <= 1'b1;
              tc_reg      <= 1'b1;
            end else begin
              counter_reg <= counter_reg - 1'b1;
            end
          end
          default: begin
            if (!down_reg) begin
              if (counter_reg >= period_reg) begin
                down_reg    <= 1'b1;
                counter_reg <= counter_reg - 1'b1;
                overflow_o  <= 1'b1;
              end else begin
                counter_reg <= counter_reg + 1'b1;
              end
            end else if (counter_reg == {CW{1'b0}}) begin
              down_reg    <= 1'b0;
              counter_reg <= counter_reg + 1'b1;
              underflow_o <= 1'b1;
              tc_reg      <= 1'b1;
            end else begin
              counter_reg <= counter_reg - 1'b1;
            end
          end
        endcase
      end
    end
  end

  // ==========================================
  // Configuration, period and compare/capture registers
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl_reg       <= `CTRL_RESET;
      period_reg     <= {CW{1'b1}};
      period_buf_reg <= {CW{1'b1}};
      cc_reg         <= {CW{1'b0}};
      cc_buf_reg     <= {CW{1'b0}};
      trig_sel_reg   <= `TRIG_SEL_RESET;
      trig_edge_reg  <= `TRIG_EDGE_RESET;
      deadtime_reg   <= 8'h00;
      intr_mask_reg  <= 2'h0;
    end else begin
      if (wr && widx == `OFF_CTRL >> 2) begin
        ctrl_reg <= wmerge_ctrl[`CTRL_W-1:0];
      end
      if (wr && widx == `OFF_TRIG_SEL >> 2) begin
        trig_sel_reg <= wmerge_tsel[`EVT_NUM*4-1:0];
      end
      if (wr && widx == `OFF_TRIG_EDGE >> 2) begin
        trig_edge_reg <= wmerge_tedg[`EVT_NUM*2-1:0];
      end
      if (wr && widx == `OFF_DEADTIME >> 2) begin
        deadtime_reg <= wmerge_dt[7:0];
      end
      if (wr && widx == `OFF_INTR_MASK >> 2) begin
        intr_mask_reg <= wmerge_msk[1:0];
      end
      if (wr && widx == `OFF_PERIOD_BUF >> 2) begin
        period_buf_reg <= wmerge_pbuf[CW-1:0];
      end
      if (wr && widx == `OFF_PERIOD >> 2) begin
        period_reg <= wmerge_per[CW-1:0];
      end else if (tc_reg && ctrl_reg[`CTRL_PBUF]) begin
        period_reg <= period_buf_reg;
      end
      if (capture_e) begin
        cc_reg     <= counter_reg;
        cc_buf_reg <= cc_reg;
      end else begin
        if (wr && widx == `OFF_CC >> 2) begin
          cc_reg <= wmerge_cc[CW-1:0];
        end else if (tc_reg && ctrl_reg[`CTRL_CBUF] && !cap_mode) begin
          cc_reg <= cc_buf_reg;
        end
        if (wr && widx == `OFF_CC_BUF >> 2) begin
          cc_buf_reg <= wmerge_cbuf[CW-1:0];
        end
      end
    end
  end

  // ==========================================
  // Interrupts: set wins over write-one-to-clear
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      intr_reg <= 2'h0;
    end else begin
      intr_reg[`INTR_TC] <= (intr_reg[`INTR_TC] & ~intr_clr[`INTR_TC]) | tc_reg;
      intr_reg[`INTR_CC] <= (intr_reg[`INTR_CC] & ~intr_clr[`INTR_CC]) | cc_match_o;
    end
  end

  assign irq_o = |(intr_reg & intr_mask_reg);

  // ==========================================
  // Output pair: PWM, dead time, kill
  always @* begin
    for (k = 0; k < CW; k = k + 1) begin
      rev_cnt[k] = counter_reg[CW-1-k];
    end
    if (mode == `MODE_PRPWM) begin
      pwm_raw = rev_cnt < cc_reg;
    end else begin
      pwm_raw = counter_reg < cc_reg;
    end
  end

  wire pwm_mode = (mode == `MODE_PWM) | (mode == `MODE_PRPWM) | (mode == `MODE_PWM_DT);

  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      kill_s1_reg  <= 1'b0;
      kill_s2_reg  <= 1'b0;
      raw_d_reg    <= 1'b0;
      dead_cnt_reg <= 8'h00;
      line_o       <= 1'b0;
      line_n_o     <= 1'b1;
    end else begin
      kill_s1_reg <= kill_i;
      kill_s2_reg <= kill_s1_reg;
      raw_d_reg   <= pwm_raw;
      if (mode == `MODE_PWM_DT && pwm_raw != raw_d_reg) begin
        dead_cnt_reg <= deadtime_reg;
      end else if (dead_cnt_reg != 8'h00 && pre_tick) begin
        dead_cnt_reg <= dead_cnt_reg - 1'b1;
      end
      if (kill_s2_reg) begin
        line_o   <= ctrl_reg[`CTRL_KILL_LVL];
        line_n_o <= ctrl_reg[`CTRL_KILL_LVL_N];
      end else if (!enable) begin
        line_o   <= 1'b0;
        line_n_o <= 1'b1;
      end else if (pwm_mode) begin
        if (mode == `MODE_PWM_DT &&
            (pwm_raw != raw_d_reg || dead_cnt_reg != 8'h00)) begin
          line_o   <= 1'b0;
          line_n_o <= 1'b0;
        end else begin
          line_o   <= pwm_raw;
          line_n_o <= ~pwm_raw;
        end
      end else if (cc_match_o) begin
        line_o   <= ~line_o;
        line_n_o <= line_o;
      end
    end
  end

endmodule

`default_nettype wire

// >>> include/timer_counter_pwm_consts.vh
`ifndef TIMER_COUNTER_PWM_CONSTS_VH
`define TIMER_COUNTER_PWM_CONSTS_VH

// ==========================================
// Register byte offsets
`define OFF_CTRL        8'h00
`define OFF_CMD         8'h04
`define OFF_COUNTER     8'h08
`define OFF_PERIOD      8'h0c
`define OFF_PERIOD_BUF  8'h10
`define OFF_CC          8'h14
`define OFF_CC_BUF      8'h18
`define OFF_TRIG_SEL    8'h1c
`define OFF_TRIG_EDGE   8'h20
`define OFF_DEADTIME    8'h24
`define OFF_INTR        8'h28
`define OFF_INTR_MASK   8'h2c
`define OFF_STATUS      8'h30

// ==========================================
// Control register fields
`define CTRL_W          13
`define CTRL_EN         0
`define CTRL_MODE_LSB   1
`define CTRL_DIR_LSB    4
`define CTRL_PRE_LSB    6
`define CTRL_PBUF       9
`define CTRL_CBUF       10
`define CTRL_KILL_LVL   11
`define CTRL_KILL_LVL_N 12
`define CTRL_RESET      13'h0000

// ==========================================
// Command register bits (write-only pulses)
`define CMD_START       0
`define CMD_RELOAD      1
`define CMD_STOP        2
`define CMD_CAPTURE     3

// ==========================================
// Operating modes
`define MODE_COMPARE    3'h0
`define MODE_CAPTURE    3'h1
`define MODE_QUAD       3'h2
`define MODE_PWM        3'h3
`define MODE_PRPWM      3'h4
`define MODE_PWM_DT     3'h5

// ==========================================
// Count directions
`define DIR_UP          2'h0
`define DIR_DOWN        2'h1
`define DIR_UPDOWN      2'h2

// ==========================================
// Event sense encodings
`define SENSE_RISE      2'h0
`define SENSE_FALL      2'h1
`define SENSE_BOTH      2'h2
`define SENSE_LEVEL     2'h3

// ==========================================
// Event slots, select fields and reset values
`define EVT_START       0
`define EVT_RELOAD      1
`define EVT_STOP        2
`define EVT_COUNT       3
`define EVT_CAPTURE     4
`define EVT_NUM         5
`define SEL_W           4
`define TRIG_SEL_RESET  20'h0f000
`define TRIG_EDGE_RESET 10'h0c0
`define INTR_TC         0
`define INTR_CC         1
`define PRE_DIV_W       7

`endif

// >>> verilog/prescaler.v
`timescale 1ns/1ps
`default_nettype none
`include "timer_counter_pwm_consts.vh"

module prescaler (
  input  wire       mclk_i,
  input  wire       sys_rst_i,
  input  wire       enable_i,
  input  wire [2:0] div_sel_i,
  output wire       tick_o
);

  reg  [`PRE_DIV_W-1:0] div_cnt_reg;
  wire [`PRE_DIV_W-1:0] mask;

  // Divide by 2**div_sel: tick when low bits are all ones
  assign mask   = ~({`PRE_DIV_W{1'b1}} << div_sel_i);
  assign tick_o = enable_i & ((div_cnt_reg & mask) == mask);

  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      div_cnt_reg <= {`PRE_DIV_W{1'b0}};
    end else if (!enable_i) begin
      div_cnt_reg <= {`PRE_DIV_W{1'b0}};
    end else begin
      div_cnt_reg <= div_cnt_reg + 1'b1;
    end
  end

endmodule

`default_nettype wire

// >>> verilog/event_sense.v
`timescale 1ns/1ps
`default_nettype none
`include "timer_counter_pwm_consts.vh"

module event_sense (
  input  wire       mclk_i,
  input  wire       sys_rst_i,
  input  wire       raw_i,
  input  wire [1:0] sense_i,
  output wire       level_o,
  output wire       prev_o,
  output reg        event_o
);

  reg sync1_reg;
  reg sync2_reg;
  reg prev_reg;

  assign level_o = sync2_reg;
  assign prev_o  = prev_reg;

  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg  <= 1'b0;
    end else begin
      sync1_reg <= raw_i;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  always @* begin
    case (sense_i)
      `SENSE_RISE: event_o = sync2_reg & ~prev_reg;
      `SENSE_FALL: event_o = ~sync2_reg & prev_reg;
      `SENSE_BOTH: event_o = sync2_reg ^ prev_reg;
      default:     event_o = sync2_reg;
    endcase
  end

endmodule

`default_nettype wire

// >>> verification/timer_counter_pwm_sva.sv
`timescale 1ns/1ps
`default_nettype none
module timer_counter_pwm_sva (
  input wire logic        mclk_i,
  input wire logic        sys_rst_i,
  input wire logic [7:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  input wire logic        kill_i,
  input wire logic        line_o,
  input wire logic        line_n_o,
  input wire logic        overflow_o,
  input wire logic        underflow_o,
  input wire logic        cc_match_o,
  input wire logic        irq_o
);
  wire cause_w = overflow_o | underflow_o | cc_match_o | avs_write_i;
  wire blank_w = avs_address_i[7:2] == 6'h01 || avs_address_i[7:2] > 6'h0c;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  // ==========================================
  // Bus handshake
  sequence s_req_wait;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  sequence s_rd_done;
    avs_read_i && !avs_waitrequest_o;
  endsequence
  a_wait_one: assert property (s_req_wait |=> !avs_waitrequest_o)
    else $error("waitrequest longer than one cycle");
  a_wait_first: assert property ($rose(avs_read_i) || $rose(avs_write_i) |-> avs_waitrequest_o)
    else $error("no wait cycle on new request");
  a_idle_nowait: assert property (!avs_read_i && !avs_write_i |-> !avs_waitrequest_o)
    else $error("waitrequest without request");
  a_rdata_hold: assert property ($changed(avs_readdata_o) |-> $past(avs_read_i))
    else $error("read data moved without read");
  a_blank_zero: assert property (s_rd_done ##0 blank_w |-> avs_readdata_o == 32'h0)
    else $error("unmapped or command read not zero");
  // ==========================================
  // Events, interrupt and kill
  a_flow_excl: assert property (!(overflow_o && underflow_o))
    else $error("overflow and underflow together");
  a_irq_cause: assert property ($rose(irq_o) |-> $past(cause_w) || $past(cause_w, 2))
    else $error("interrupt without event");
  a_kill_force: assert property ((kill_i && !avs_write_i)[*6] |-> $stable(line_o) && $stable(line_n_o))
    else $error("outputs move under kill");
endmodule
bind timer_counter_pwm_unit timer_counter_pwm_sva sva (.*);
`default_nettype wire

// >>> verification/trig_route_model.sv
`timescale 1ns/1ps
`default_nettype none
module trig_route_model (
  input  wire logic        mclk_i,
  input  wire logic        irq_i,
  output var  logic [14:0] trig_o,
  output var  logic        kill_o,
  output var  logic [7:0]  irq_cnt_o
);
  logic irq_prev = 1'h0;
  initial begin
    trig_o = 15'h0;
    kill_o = 1'h0;
    irq_cnt_o = 8'h0;
  end
  // ==========================================
  // Routed triggers and kill, moved just after an edge
  task automatic set_trig(input int idx, input logic v);
    @(posedge mclk_i);
    trig_o[idx] <= v;
  endtask
  task automatic set_kill(input logic v);
    @(posedge mclk_i);
    kill_o <= v;
  endtask
  // ==========================================
  // Interrupt controller counts requests
  always @(posedge mclk_i) begin
    irq_prev <= irq_i;
    if (irq_i && !irq_prev) irq_cnt_o <= irq_cnt_o + 8'h1;
  end
endmodule
`default_nettype wire

// >>> verification/timer_counter_pwm_unit_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "timer_counter_pwm_consts.vh"
module timer_counter_pwm_unit_tb;
  logic        mclk_i = 1'h0;
  logic        sys_rst_i = 1'h1;
  logic [7:0]  avs_address_i = 8'h0;
  logic        avs_read_i = 1'h0;
  logic        avs_write_i = 1'h0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0]  avs_byteenable_i = 4'hf;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic [14:0] trig_i;
  logic        kill_i;
  logic        line_o;
  logic        line_n_o;
  logic        overflow_o;
  logic        underflow_o;
  logic        cc_match_o;
  logic        irq_o;
  logic [7:0]  irq_cnt;
  logic [31:0] rd;
  int          error_cnt = 0;
  int          samples_checked = 0;
  int          c;
  int          hi;
  wire  [2:0]  ev_w = {cc_match_o, underflow_o, overflow_o};
  logic [7:0]  ra [7] = '{`OFF_CTRL, `OFF_PERIOD, `OFF_TRIG_SEL, `OFF_TRIG_EDGE, `OFF_CMD,
                          `OFF_INTR_MASK, 8'h3c};
  logic [31:0] rv [7] = '{32'h0, 32'hffff, 32'hf000, 32'hc0, 32'h0, 32'h0, 32'h0};
  logic [1:0]  dd [4] = '{`DIR_UP, `DIR_DOWN, `DIR_UP, `DIR_UPDOWN};
  logic [2:0]  pp [4] = '{3'h0, 3'h3, 3'h7, 3'h1};
  always #4 mclk_i = ~mclk_i;
  timer_counter_pwm_unit #(.CNT_WIDTH(16), .TRIG_COUNT(15)) dut (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .trig_i(trig_i), .kill_i(kill_i),
    .line_o(line_o), .line_n_o(line_n_o), .overflow_o(overflow_o),
    .underflow_o(underflow_o), .cc_match_o(cc_match_o), .irq_o(irq_o)
  );
  trig_route_model far (.mclk_i(mclk_i), .irq_i(irq_o), .trig_o(trig_i), .kill_o(kill_i),
                        .irq_cnt_o(irq_cnt));
  // ==========================================
  // Helpers
  task automatic err(input string m);
    error_cnt++;
    $display("[ERR] %0t %s", $time, m);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    samples_checked++;
    if (g !== e) err($sformatf("%s got %h exp %h", m, g, e));
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    do begin
      @(posedge mclk_i);
      n++;
    end while (avs_waitrequest_o !== 1'h0 && n < 50);
    if (n >= 50) err("bus hang");
    rd = avs_readdata_o;
    avs_write_i <= 1'h0;
    avs_read_i <= 1'h0;
    @(negedge mclk_i);
  endtask
  task automatic wait_ev(input int k);
    c = 0;
    do begin
      @(negedge mclk_i);
      c++;
    end while (ev_w[k] !== 1'h1 && c < 3000);
    if (c >= 3000) err("no pulse");
  endtask
  function automatic [31:0] cw(input [2:0] m, input [1:0] dr, input [2:0] p);
    cw = {23'h0, p, dr, m, 1'h1};
  endfunction
  task automatic go(input logic [31:0] ctl);
    bus(1'h1, `OFF_CTRL, ctl);
    bus(1'h1, `OFF_CMD, 32'h2);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ==========================================
  // Tests
  initial begin
    repeat (8) @(posedge mclk_i);
    sys_rst_i <= 1'h0;
    foreach (ra[i]) begin
      bus(1'h0, ra[i], 32'h0);
      chk(rd, rv[i], "reset value");
    end
    $display("test reset done");
    bus(1'h1, `OFF_PERIOD, 32'h3);
    bus(1'h1, `OFF_INTR_MASK, 32'h1);
    foreach (dd[i]) begin
      go(cw(`MODE_COMPARE, dd[i], pp[i]));
      wait_ev(dd[i] == `DIR_UP ? 0 : 1);
      wait_ev(dd[i] == `DIR_UP ? 0 : 1);
      if (dd[i] != `DIR_UPDOWN) chk(c, 32'h4 << pp[i], "tc interval");
      @(negedge mclk_i);
      chk(irq_o, 32'h1, "irq on tc");
    end
    chk(irq_cnt != 8'h0, 32'h1, "irq seen");
    bus(1'h1, `OFF_CTRL, 32'h0);
    bus(1'h1, `OFF_INTR_MASK, 32'h0);
    chk(irq_o, 32'h0, "masked");
    bus(1'h1, `OFF_INTR_MASK, 32'h1);
    chk(irq_o, 32'h1, "unmasked");
    bus(1'h1, `OFF_INTR, 32'h3);
    bus(1'h0, `OFF_INTR, 32'h0);
    chk(rd, 32'h0, "cleared");
    chk(irq_o, 32'h0, "irq cleared");
    $display("test count done");
    bus(1'h1, `OFF_PERIOD, 32'h5);
    bus(1'h1, `OFF_CC, 32'h2);
    go(cw(`MODE_COMPARE, `DIR_UP, 3'h0));
    wait_ev(2);
    wait_ev(2);
    chk(c, 32'h6, "compare interval");
    go(cw(`MODE_CAPTURE, `DIR_UP, 3'h0));
    bus(1'h1, `OFF_INTR, 32'h3);
    bus(1'h1, `OFF_CMD, 32'h8);
    bus(1'h0, `OFF_INTR, 32'h0);
    chk(rd & 32'h2, 32'h2, "capture intr");
    $display("test compare done");
    bus(1'h1, `OFF_PERIOD, 32'h3);
    bus(1'h1, `OFF_PERIOD_BUF, 32'h7);
    go(cw(`MODE_COMPARE, `DIR_UP, 3'h0) | 32'h200);
    wait_ev(0);
    wait_ev(0);
    chk(c, 32'h8, "buffered period");
    bus(1'h1, `OFF_CTRL, 32'h0);
    bus(1'h0, `OFF_PERIOD, 32'h0);
    chk(rd, 32'h7, "period swapped");
    $display("test buffer done");
    bus(1'h1, `OFF_PERIOD, 32'h9);
    bus(1'h1, `OFF_CC, 32'h4);
    for (int m = 0; m < 2; m++) begin
      go(cw(m ? `MODE_PRPWM : `MODE_PWM, `DIR_UP, 3'h0));
      hi = 0;
      repeat (10) begin
        @(negedge mclk_i);
        hi += line_o;
        chk(line_n_o, !line_o, "pair");
      end
      chk(hi, m ? 32'h1 : 32'h4, "duty");
    end
    bus(1'h1, `OFF_CTRL, cw(`MODE_PWM, `DIR_UP, 3'h0) | 32'h1800);
    far.set_kill(1'h1);
    repeat (8) @(negedge mclk_i);
    chk({line_o, line_n_o}, 32'h3, "kill state");
    far.set_kill(1'h0);
    $display("test pwm done");
    bus(1'h1, `OFF_TRIG_SEL, 32'hf002);
    bus(1'h1, `OFF_TRIG_EDGE, 32'hc1);
    bus(1'h1, `OFF_CMD, 32'h4);
    far.set_trig(2, 1'h1);
    repeat (6) @(negedge mclk_i);
    bus(1'h0, `OFF_STATUS, 32'h0);
    chk(rd[0], 32'h0, "rise ignored");
    far.set_trig(2, 1'h0);
    repeat (6) @(negedge mclk_i);
    bus(1'h0, `OFF_STATUS, 32'h0);
    chk(rd[0], 32'h1, "fall starts");
    $display("test events done");
    tally_and_finish;
  end
  initial begin
    repeat (20000) @(posedge mclk_i);
    err("watchdog");
    tally_and_finish;
  end
endmodule
`default_nettype wire
